// *** rtl/uedp_top.sv ***
`timescale 1ns/1ps
module uedp_top #(
	parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
	parameter logic [15:0] PRODUCT_ID = 16'h5678, // arbitrary value
	parameter logic [15:0] DEVICE_REL = 16'h0100, // arbitrary value
	parameter int RAM_DEPTH = 6977
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// setup packet
	input wire logic setup_valid,
	input wire logic [63:0] setup_data,
	// in data stage
	output logic in_valid,
	output logic [7:0] in_data,
	input wire logic in_ready,
	// out data stage
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	output logic out_ready,
	// request status
	output logic req_done,
	output logic req_to_cpu,
	// device state
	output logic request_owner_select,
	output logic cpu_reset,
	output logic [6:0] function_address_reg,
	// eeprom byte stream
	input wire logic ee_none,
	input wire logic ee_valid,
	input wire logic [7:0] ee_byte
);
	import uedp_pkg::*;
	typedef enum logic [2:0] {H_IDLE, H_FETCH, H_WAIT, H_SEND, H_RECV, H_DONE} uedp_hst_t;
	typedef enum logic [2:0] {K_ZERO2, K_STATUS_EP, K_CONFIG, K_ALT, K_DESC, K_UPLOAD} uedp_kind_t;
	uedp_hst_t st;
	uedp_kind_t kind, next_kind;
	logic [15:0] ptr, addr, rlen;
	logic [7:0] config_num;
	logic [1:0] alt;
	logic [31:0] stall;
	logic [4:0] sel_q;
	logic boot_seen;
	logic boot_done, b_wr;
	uedp_mode_t mode;
	logic [47:0] ee_ids, ids;
	logic [15:0] b_addr;
	logic [7:0] b_data;
	uedp_mem_if mem();
	uedp_boot u_boot (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.ee_none(ee_none),
		.ee_valid(ee_valid),
		.ee_byte(ee_byte),
		.boot_done(boot_done),
		.mode(mode),
		.ids(ee_ids),
		.wr_en(b_wr),
		.wr_addr(b_addr),
		.wr_data(b_data)
	);
	logic take, fw_in, fw_out, std_req, to_cpu_req, ep_rcp;
	logic set_addr, set_config, set_iface, set_stall, clr_stall;
	logic in_fire, out_fire, last_byte, dl_ram, dl_cpu_control_status, boot_ram, boot_cpu_control_status;
	logic apb_access, apb_fire, reg_hit;
	logic [31:0] reg_rdata;
	logic [7:0] s_rt, s_rq, reply, upload_byte;
	logic [15:0] s_val, s_idx, s_len, natural_len, want_len;
	logic [4:0] s_sel;
	uedp_ram #(
		.DEPTH(RAM_DEPTH)
	) u_ram (
		.pclk(pclk),
		.ce(ce),
		.mem(mem)
	);

	function automatic logic [15:0] min_len(input logic [15:0] a, input logic [15:0] b);
		min_len = (a < b) ? a : b;
	endfunction

	// stall slot: endpoint number and direction bit
	function automatic logic [4:0] ep_slot(input logic [15:0] windex);
		ep_slot = {windex[3:0], windex[7]};
	endfunction

	function automatic logic [7:0] desc_byte(input logic [4:0] i, input logic [47:0] id);
		case (i)
		5'h00: desc_byte = LEN_DESC_DEV[7:0];
		5'h01: desc_byte = DESC_DEVICE;
		5'h02: desc_byte = USB_REL[7:0];
		5'h03: desc_byte = USB_REL[15:8];
		5'h07: desc_byte = EP0_MAX_PACKET;
		5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D: desc_byte = id[8 * (i - 5'h08) +: 8];
		5'h11: desc_byte = DESC_NUM_CONFIGS;
		default: desc_byte = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] reply_byte(input uedp_kind_t k, input logic [15:0] i,
		input logic stall_bit, input logic [7:0] cfg, input logic [1:0] a,
		input logic [47:0] id);
		case (k)
		K_STATUS_EP: reply_byte = (i == 16'h0000) ? {7'h00, stall_bit} : 8'h00;
		K_CONFIG: reply_byte = cfg;
		K_ALT: reply_byte = {6'h00, a};
		K_DESC: reply_byte = desc_byte(i[4:0], id);
		default: reply_byte = 8'h00;
		endcase
	endfunction

	// identifiers from the image only in the ids mode
	assign ids = (mode == MODE_EE_IDS) ? ee_ids : {DEVICE_REL, PRODUCT_ID, VENDOR_ID};

	// setup fields, little endian on the wire
	assign s_rt = setup_data[7:0];
	assign s_rq = setup_data[15:8];
	assign s_val = setup_data[31:16];
	assign s_idx = setup_data[47:32];
	assign s_len = setup_data[63:48];
	assign s_sel = ep_slot(s_idx);
	// setups are ignored until the boot pass has finished
	assign take = ce && st == H_IDLE && setup_valid && boot_done;
	assign fw_out = s_rq == RQ_FW_LOAD && s_rt == RT_VENDOR_OUT;
	assign fw_in = s_rq == RQ_FW_LOAD && s_rt == RT_VENDOR_IN;
	assign std_req = !fw_out && !fw_in && !request_owner_select && s_rt[6:5] == RT_STANDARD;
	assign to_cpu_req = !fw_out && !fw_in && request_owner_select;
	assign ep_rcp = s_rt[4:0] == RCP_EP;
	// every other code falls through with no update
	assign set_addr = take && std_req && s_rq == RQ_SET_ADDRESS;
	assign set_config = take && std_req && s_rq == RQ_SET_CONFIG;
	assign set_iface = take && std_req && s_rq == RQ_SET_IFACE;
	assign set_stall = take && std_req && ep_rcp && s_rq == RQ_SET_FEATURE;
	assign clr_stall = take && std_req && ep_rcp && s_rq == RQ_CLR_FEATURE;

	always_comb begin
		next_kind = K_ZERO2;
		natural_len = 16'h0000;
		if (fw_in) begin
			next_kind = K_UPLOAD;
			natural_len = s_len;
		end else if (std_req) begin
			case (s_rq)
			RQ_GET_STATUS: begin
				next_kind = ep_rcp ? K_STATUS_EP : K_ZERO2;
				natural_len = LEN_STATUS;
			end
			RQ_GET_DESC: begin
				next_kind = K_DESC;
				natural_len = (s_val[15:8] == DESC_DEVICE) ? LEN_DESC_DEV : 16'h0000;
			end
			RQ_GET_CONFIG: begin
				next_kind = K_CONFIG;
				natural_len = LEN_BYTE;
			end
			RQ_GET_IFACE: begin
				next_kind = K_ALT;
				natural_len = LEN_BYTE;
			end
			default: natural_len = 16'h0000;
			endcase
		end
	end
	assign want_len = min_len(s_len, natural_len);

	assign in_fire = st == H_SEND && in_valid && in_ready;
	assign out_fire = st == H_RECV && out_valid && out_ready;
	assign last_byte = ptr + 16'h0001 == rlen;
	// downloads land in ram or the cpu control bit only
	assign dl_ram = out_fire && is_ram_addr(addr);
	assign dl_cpu_control_status = out_fire && is_cpu_control_status_addr(addr);
	assign boot_ram = b_wr && is_ram_addr(b_addr);
	assign boot_cpu_control_status = b_wr && is_cpu_control_status_addr(b_addr);
	assign mem.we = boot_ram || dl_ram;
	assign mem.addr = b_wr ? b_addr : addr;
	assign mem.wdata = b_wr ? b_data : out_data;
	assign reply = reply_byte(kind, ptr, stall[sel_q], config_num, alt, ids);
	always_comb begin
		upload_byte = 8'h00;
		if (is_ram_addr(addr))
			upload_byte = mem.rdata;
		else if (is_cpu_control_status_addr(addr))
			upload_byte = {7'h00, cpu_reset};
	end

	// request sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= H_IDLE;
			kind <= K_ZERO2;
			ptr <= 16'h0000;
			addr <= 16'h0000;
			rlen <= 16'h0000;
			sel_q <= 5'h00;
		end else if (ce) begin
			case (st)
			H_IDLE: if (take) begin
				kind <= next_kind;
				ptr <= 16'h0000;
				addr <= s_val;
				sel_q <= s_sel;
				if (fw_out) begin
					rlen <= s_len;
					st <= (s_len == 16'h0000) ? H_DONE : H_RECV;
				end else begin
					rlen <= want_len;
					st <= (want_len == 16'h0000) ? H_DONE : H_FETCH;
				end
			end
			// ram read address goes out here, data stands in the wait state
			H_FETCH: st <= H_WAIT;
			H_WAIT: st <= H_SEND;
			H_SEND: if (in_fire) begin
				ptr <= ptr + 16'h0001;
				addr <= addr + 16'h0001;
				st <= last_byte ? H_DONE : H_FETCH;
			end
			H_RECV: if (out_fire) begin
				ptr <= ptr + 16'h0001;
				addr <= addr + 16'h0001;
				if (last_byte)
					st <= H_DONE;
			end
			H_DONE: st <= H_IDLE;
			default: st <= H_IDLE;
			endcase
		end
	end

	// in data stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_valid <= 1'b0;
			in_data <= 8'h00;
		end else if (ce) begin
			if (st == H_WAIT) begin
				in_valid <= 1'b1;
				in_data <= (kind == K_UPLOAD) ? upload_byte : reply;
			end else if (in_fire)
				in_valid <= 1'b0;
		end
	end

	// out data stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			out_ready <= 1'b0;
		else if (ce) begin
			if (take && fw_out && s_len != 16'h0000)
				out_ready <= 1'b1;
			else if (out_fire && last_byte)
				out_ready <= 1'b0;
		end
	end

	// completion and hand-off strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_done <= 1'b0;
			req_to_cpu <= 1'b0;
		end else if (ce) begin
			req_done <= st == H_DONE;
			req_to_cpu <= take && to_cpu_req;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			function_address_reg <= 7'h00;
		else if (ce && set_addr)
			function_address_reg <= s_val[6:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_num <= 8'h00;
			alt <= 2'h0;
		end else if (ce) begin
			if (set_config)
				config_num <= s_val[7:0];
			if (set_iface)
				alt <= s_val[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stall <= 32'h00000000;
		else if (ce) begin
			if (set_stall)
				stall[s_sel] <= 1'b1;
			else if (clr_stall)
				stall[s_sel] <= 1'b0;
		end
	end

	// owner bit: after boot set only if the load boot ran, then written over the register bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_seen <= 1'b0;
			request_owner_select <= OWNER_RST;
		end else if (ce) begin
			if (boot_done && !boot_seen) begin
				boot_seen <= 1'b1;
				request_owner_select <= mode == MODE_EE_LOAD;
			end else if (apb_fire && pwrite && paddr == A_USB_CONTROL_STATUS)
				request_owner_select <= pwdata[OWNER_BIT];
		end
	end

	// boot bytes, downloads and register writes to the cpu control address drive the processor reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cpu_reset <= CPU_RESET_RST;
		else if (ce) begin
			if (boot_cpu_control_status)
				cpu_reset <= b_data[CPU_RESET_BIT];
			else if (dl_cpu_control_status)
				cpu_reset <= out_data[CPU_RESET_BIT];
			else if (apb_fire && pwrite && paddr == A_CPU_CONTROL_STATUS)
				cpu_reset <= pwdata[CPU_RESET_BIT];
		end
	end

	// register bus: one wait state, data and error stand with pready
	assign apb_access = psel && penable;
	assign apb_fire = apb_access && pready;
	always_comb begin
		reg_rdata = 32'h00000000;
		reg_hit = 1'b1;
		case (paddr)
		A_USB_CONTROL_STATUS: reg_rdata[OWNER_BIT] = request_owner_select;
		A_CPU_CONTROL_STATUS: reg_rdata[CPU_RESET_BIT] = cpu_reset;
		A_FNADDR: reg_rdata[6:0] = function_address_reg;
		A_CONFIG: reg_rdata[7:0] = config_num;
		A_ALT: reg_rdata[1:0] = alt;
		A_STALL: reg_rdata = stall;
		A_BOOT: reg_rdata[2:0] = {mode, boot_done};
		A_VIDPID: reg_rdata = ids[31:0];
		A_DID: reg_rdata[15:0] = ids[47:32];
		default: reg_hit = 1'b0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= apb_access && !pready;
			if (apb_access && !pready) begin
				prdata <= reg_rdata;
				pslverr <= !reg_hit;
			end
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_byte_offered;
		in_valid && !in_ready;
	endsequence
	sequence s_load_taken;
		take && (fw_in || fw_out);
	endsequence
	a_in_byte_held: assert property (s_byte_offered |=> in_valid && $stable(in_data))
		else $error("in byte dropped before taken");
	a_load_in_hw: assert property (s_load_taken |=> !req_to_cpu && st != H_IDLE)
		else $error("load request not served");
	a_owner_hands_off: assert property (take && to_cpu_req |=> req_to_cpu)
		else $error("owned request not handed off");
	a_addr_loaded: assert property (set_addr |=> function_address_reg == $past(s_val[6:0]))
		else $error("function address not loaded");
	a_stall_set: assert property (set_stall |=> stall[sel_q])
		else $error("stall bit not set");
	a_stall_clear: assert property (clr_stall |=> !stall[sel_q])
		else $error("stall bit not cleared");
	a_ram_only: assert property (dl_ram |-> is_ram_addr(mem.addr))
		else $error("download outside memory");
endmodule

// *** rtl/uedp_pkg.sv ***
package uedp_pkg;
	localparam logic [7:0] RQ_GET_STATUS = 8'h00;
	localparam logic [7:0] RQ_CLR_FEATURE = 8'h01;
	localparam logic [7:0] RQ_SET_FEATURE = 8'h03;
	localparam logic [7:0] RQ_SET_ADDRESS = 8'h05;
	localparam logic [7:0] RQ_GET_DESC = 8'h06;
	localparam logic [7:0] RQ_GET_CONFIG = 8'h08;
	localparam logic [7:0] RQ_SET_CONFIG = 8'h09;
	localparam logic [7:0] RQ_GET_IFACE = 8'h0A;
	localparam logic [7:0] RQ_SET_IFACE = 8'h0B;
	localparam logic [7:0] RQ_FW_LOAD = 8'hA0;
	localparam logic [7:0] RT_VENDOR_OUT = 8'h40;
	localparam logic [7:0] RT_VENDOR_IN = 8'hC0;
	localparam logic [1:0] RT_STANDARD = 2'h0;
	localparam logic [4:0] RCP_DEVICE = 5'h00;
	localparam logic [4:0] RCP_EP = 5'h02;
	localparam logic [7:0] DESC_DEVICE = 8'h01;
	localparam logic [15:0] USB_REL = 16'h0110;
	localparam logic [7:0] EP0_MAX_PACKET = 8'h40;
	localparam logic [7:0] DESC_NUM_CONFIGS = 8'h01;
	localparam logic [15:0] LEN_DESC_DEV = 16'h0012;
	localparam logic [15:0] LEN_STATUS = 16'h0002;
	localparam logic [15:0] LEN_BYTE = 16'h0001;
	localparam logic [15:0] RAM_LAST = 16'h1B40;
	localparam logic [15:0] CPU_CONTROL_STATUS_ADDR = 16'h7F92;
	localparam logic [7:0] EE_IDS_ONLY = 8'hB0;
	localparam logic [7:0] EE_LOAD = 8'hB2;
	localparam logic [2:0] EE_ID_LAST = 3'h5;
	localparam int REC_LAST_BIT = 7;
	localparam int OWNER_BIT = 1;
	localparam int CPU_RESET_BIT = 0;
	localparam logic OWNER_RST = 1'b0;
	localparam logic CPU_RESET_RST = 1'b1;
	localparam logic [7:0] A_USB_CONTROL_STATUS = 8'h00;
	localparam logic [7:0] A_CPU_CONTROL_STATUS = 8'h04;
	localparam logic [7:0] A_FNADDR = 8'h08;
	localparam logic [7:0] A_CONFIG = 8'h0C;
	localparam logic [7:0] A_ALT = 8'h10;
	localparam logic [7:0] A_STALL = 8'h14;
	localparam logic [7:0] A_BOOT = 8'h18;
	localparam logic [7:0] A_VIDPID = 8'h1C;
	localparam logic [7:0] A_DID = 8'h20;
	typedef enum logic [1:0] {MODE_INTERNAL, MODE_EE_IDS, MODE_EE_LOAD} uedp_mode_t;
	function automatic logic is_ram_addr(input logic [15:0] a);
		is_ram_addr = a <= RAM_LAST;
	endfunction
	function automatic logic is_cpu_control_status_addr(input logic [15:0] a);
		is_cpu_control_status_addr = a == CPU_CONTROL_STATUS_ADDR;
	endfunction
endpackage

// *** rtl/uedp_mem_if.sv ***
`timescale 1ns/1ps
interface uedp_mem_if;
	logic we;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport master(output we, addr, wdata, input rdata);
	modport ram(input we, addr, wdata, output rdata);
endinterface

// *** rtl/uedp_ram.sv ***
`timescale 1ns/1ps
module uedp_ram #(
	parameter int DEPTH = 6977
) (
	// clock
	input wire logic pclk,
	input wire logic ce,
	// port
	uedp_mem_if.ram mem
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] store [DEPTH];
	// one-cycle registered read
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (mem.we)
				store[mem.addr[AW-1:0]] <= mem.wdata;
			mem.rdata <= store[mem.addr[AW-1:0]];
		end
	end
endmodule

// *** rtl/uedp_boot.sv ***
`timescale 1ns/1ps
module uedp_boot (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// eeprom byte stream
	input wire logic ee_none,
	input wire logic ee_valid,
	input wire logic [7:0] ee_byte,
	// result
	output logic boot_done,
	output uedp_pkg::uedp_mode_t mode,
	output logic [47:0] ids,
	// memory writes
	output logic wr_en,
	output logic [15:0] wr_addr,
	output logic [7:0] wr_data
);
	import uedp_pkg::*;
	typedef enum logic [2:0] {B_FIRST, B_ID, B_LENH, B_LENL, B_ADRH, B_ADRL, B_DATA, B_DONE}
		uedp_boot_st_t;
	uedp_boot_st_t st;
	logic [2:0] n;
	logic [9:0] len;
	logic last;
	logic [15:0] addr;
	assign boot_done = st == B_DONE;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= B_FIRST;
			mode <= MODE_INTERNAL;
			ids <= 48'h0;
			n <= 3'h0;
			len <= 10'h0;
			last <= 1'b0;
			addr <= 16'h0;
			wr_en <= 1'b0;
			wr_addr <= 16'h0;
			wr_data <= 8'h00;
		end else if (ce) begin
			wr_en <= 1'b0;
			case (st)
			B_FIRST: begin
				if (ee_none)
					st <= B_DONE;
				else if (ee_valid) begin
					n <= 3'h0;
					if (ee_byte == EE_IDS_ONLY) begin
						mode <= MODE_EE_IDS;
						st <= B_ID;
					end else if (ee_byte == EE_LOAD) begin
						mode <= MODE_EE_LOAD;
						st <= B_ID;
					end else
						st <= B_DONE;
				end
			end
			B_ID: if (ee_valid) begin
				ids <= {ee_byte, ids[47:8]};
				n <= n + 3'h1;
				if (n == EE_ID_LAST)
					st <= (mode == MODE_EE_LOAD) ? B_LENH : B_DONE;
			end
			B_LENH: if (ee_valid) begin
				last <= ee_byte[REC_LAST_BIT];
				len[9:8] <= ee_byte[1:0];
				st <= B_LENL;
			end
			B_LENL: if (ee_valid) begin
				len[7:0] <= ee_byte;
				st <= B_ADRH;
			end
			B_ADRH: if (ee_valid) begin
				addr[15:8] <= ee_byte;
				st <= B_ADRL;
			end
			B_ADRL: if (ee_valid) begin
				addr[7:0] <= ee_byte;
				if (len == 10'h0)
					st <= last ? B_DONE : B_LENH;
				else
					st <= B_DATA;
			end
			B_DATA: if (ee_valid) begin
				wr_en <= 1'b1;
				wr_addr <= addr;
				wr_data <= ee_byte;
				addr <= addr + 16'h1;
				len <= len - 10'h1;
				if (len == 10'h1)
					st <= last ? B_DONE : B_LENH;
			end
			B_DONE: st <= B_DONE;
			default: st <= B_DONE;
			endcase
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_load_writes_ram: assert property (ce && st == B_DATA && ee_valid |=> wr_en)
		else $error("load byte not written");
	a_ids_mode_quiet: assert property (mode != MODE_EE_LOAD |-> !wr_en)
		else $error("memory written outside load boot");
endmodule

// *** sim/uedp_host_model.sv ***
`timescale 1ns/1ps
module uedp_host_model (
	// clock
	input wire logic pclk,
	// setup and data stages
	output logic setup_valid,
	output logic [63:0] setup_data,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [7:0] out_data,
	input wire logic out_ready,
	input wire logic req_done
);
	initial begin
		setup_valid = 1'b0;
		setup_data = 64'h0;
		in_ready = 1'b0;
		out_valid = 1'b0;
		out_data = 8'h00;
	end
	// caller picks request type, code, value, index and length
	task automatic xfer(input logic [7:0] rt, rq, input logic [15:0] val, idx, len, wd,
		output logic [15:0] rd);
		rd = 16'h0000;
		@(posedge pclk);
		setup_valid <= 1'b1;
		setup_data <= {len, idx, val, rq, rt};
		@(posedge pclk);
		setup_valid <= 1'b0;
		setup_data <= ~setup_data;
		in_ready <= rt[7];
		for (int i = 0; i < len; i++) begin
			if (!rt[7]) begin
				out_valid <= 1'b1;
				out_data <= wd[8 * (i % 2) +: 8];
			end
			do @(posedge pclk);
			while ((rt[7] ? in_valid : out_ready) !== 1'b1);
			if (rt[7] && i < 2)
				rd[8 * i +: 8] = in_data;
		end
		in_ready <= 1'b0;
		out_valid <= 1'b0;
		out_data <= ~out_data;
		do @(posedge pclk);
		while (req_done !== 1'b1);
	endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import uedp_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic e;
	int to_cpu_n = 0;
	logic pready, pslverr, setup_valid, in_valid, in_ready, out_valid, out_ready, req_done;
	logic owner, cpu_reset, to_cpu;
	logic [63:0] setup_data;
	logic [7:0] in_data, out_data;
	logic [6:0] fn_addr;
	logic [15:0] rd;
	logic [7:0] odd [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h0C, 8'h55};
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	always #5 pclk = ~pclk;
	uedp_top uedp_top_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .setup_valid(setup_valid),
		.setup_data(setup_data), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
		.out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
		.req_done(req_done), .req_to_cpu(to_cpu), .request_owner_select(owner),
		.cpu_reset(cpu_reset), .function_address_reg(fn_addr), .ee_none(1'b1),
		.ee_valid(1'b0), .ee_byte(8'h00));
	uedp_host_model uedp_host_model_i (.pclk(pclk), .setup_valid(setup_valid),
		.setup_data(setup_data), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
		.out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
		.req_done(req_done));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic ctl(input logic [7:0] rt, rq, input logic [15:0] val, idx, len, wd);
		uedp_host_model_i.xfer(rt, rq, val, idx, len, wd, rd);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (to_cpu === 1'b1)
			to_cpu_n++;
		if (cycles == 30000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(owner, 1'b0, "owner");
		apb(1'b0, A_USB_CONTROL_STATUS, 32'h0);
		chk(r[OWNER_BIT], 1'b0, "usb_control_status");
		$display("test reset done");
		ctl(8'h00, RQ_SET_ADDRESS, 16'h0005, 16'h0, 16'h0, 16'h0);
		chk(fn_addr, 7'h05, "fn_addr");
		ctl(8'h80, RQ_GET_DESC, {DESC_DEVICE, 8'h00}, 16'h0, 16'h0002, 16'h0);
		chk(rd, {DESC_DEVICE, LEN_DESC_DEV[7:0]}, "desc");
		ctl(8'h00, RQ_SET_CONFIG, 16'h0001, 16'h0, 16'h0, 16'h0);
		ctl(8'h01, RQ_SET_IFACE, 16'h0003, 16'h0, 16'h0, 16'h0);
		for (int i = 0; i < 7; i++) ctl(8'h00, odd[i], 16'h0007, 16'h0, 16'h0, 16'h0);
		ctl(8'h80, RQ_GET_CONFIG, 16'h0, 16'h0, LEN_BYTE, 16'h0);
		chk(rd, 16'h0001, "config");
		ctl(8'h81, RQ_GET_IFACE, 16'h0, 16'h0, LEN_BYTE, 16'h0);
		chk(rd, 16'h0003, "alt");
		for (int t = 8'h80; t < 8'h82; t++) begin
			ctl(t, RQ_GET_STATUS, 16'h0, 16'h0, LEN_STATUS, 16'h0);
			chk(rd, 16'h0000, "status");
		end
		for (int s = 1; s >= 0; s--) begin
			ctl(8'h02, s ? RQ_SET_FEATURE : RQ_CLR_FEATURE, 16'h0, 16'h0082, 16'h0, 16'h0);
			ctl(8'h82, RQ_GET_STATUS, 16'h0, 16'h0082, LEN_STATUS, 16'h0);
			chk(rd, s, "stall");
		end
		$display("test standard done");
		apb(1'b1, A_USB_CONTROL_STATUS, 32'h2);
		@(posedge pclk);
		chk(owner, 1'b1, "owner_set");
		ctl(8'h00, RQ_SET_CONFIG, 16'h0005, 16'h0, 16'h0, 16'h0);
		chk(to_cpu_n, 1, "to_cpu");
		ctl(RT_VENDOR_OUT, RQ_FW_LOAD, RAM_LAST - 16'h1, 16'h0, 16'h0002, 16'hB44B);
		ctl(RT_VENDOR_IN, RQ_FW_LOAD, RAM_LAST - 16'h1, 16'h0, 16'h0002, 16'h0);
		chk(rd, 16'hB44B, "ram");
		for (int v = 1; v >= 0; v--) begin
			ctl(RT_VENDOR_OUT, RQ_FW_LOAD, CPU_CONTROL_STATUS_ADDR, 16'h0, LEN_BYTE, v);
			chk(cpu_reset, v, "cpu_reset");
		end
		$display("test load done");
		apb(1'b1, 8'hFC, 32'hFFFFFFFF);
		chk(e, 1'b1, "slverr");
		apb(1'b0, A_CONFIG, 32'h0);
		chk(e, 1'b0, "slverr_ok");
		chk(r, 32'h1, "config_reg");
		$display("test registers done");
		final_report();
	end
endmodule
